// ===== src/uge_pkg.sv
/*
  Shared constants and types of the serial GPIO expander.
  Assumes a single 250 MHz system clock drives every block.
*/
package uge_pkg;
  localparam int MCLK_MHZ      = 250;
  localparam int INPUT_CLK_MHZ = 48;
  localparam int UART_CLK_MHZ  = 20;
  localparam int UART_CLK_HZ   = UART_CLK_MHZ * 1000000;
  localparam int BAUD_RATE     = 9600;
  localparam int OVERSAMPLE    = 16;
  localparam int BAUD_DIV_INT  = UART_CLK_HZ / (OVERSAMPLE * BAUD_RATE) - 1;

  localparam logic [7:0] BAUD_DIV    = BAUD_DIV_INT[7:0];
  localparam logic [8:0] ACC_STEP    = 9'(UART_CLK_MHZ);
  localparam logic [8:0] ACC_WRAP    = 9'(MCLK_MHZ);
  localparam logic [3:0] MID_SAMPLE  = 4'h7;
  localparam logic [3:0] LAST_SAMPLE = 4'hf;
  localparam logic [3:0] BITS_8      = 4'h8;
  localparam logic [3:0] BITS_7      = 4'h7;
  localparam logic [3:0] FRAME_EXTRA = 4'h2;
  localparam logic [3:0] SHIFT_W     = 4'h9;

  localparam int NUM_PORTS = 4;
  localparam int PORT_W    = 8;
  localparam int ADDR_MSB  = 7;
  localparam int ADDR_LSB  = 5;
  localparam int ADDR_IDX  = 6;
  localparam int DIR_MSB   = 3;

  localparam logic [2:0] LAST_PORT  = 3'h3;
  localparam logic [7:0] DIR_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] READ_NONE  = 8'h00;

  typedef enum logic [1:0] {
    ST_WAIT_ADDR,
    ST_WAIT_DATA,
    ST_SEND_READ,
    ST_WAIT_TX
  } uge_state_t;
endpackage

// ===== src/uge_uart_if.sv
/*
  Signals between the control logic and the UART core.
  Assumes both ends share mclk and its clock enable.
*/
`timescale 1ns/1ps
interface uge_uart_if;
  logic       tick20;
  logic       char8;
  logic       par_en;
  logic       par_odd;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_err;
  logic [7:0] tx_data;
  logic       tx_start;
  logic       tx_busy;
  logic       tx_line;

  modport core (
    input  tick20, char8, par_en, par_odd, tx_data, tx_start,
    output rx_data, rx_valid, rx_err, tx_busy, tx_line
  );
  modport ctrl (
    output tick20, char8, par_en, par_odd, tx_data, tx_start,
    input  rx_data, rx_valid, rx_err, tx_busy, tx_line
  );
endinterface

// ===== src/uge_uart.sv
/*
  UART core with 16x oversampling, 7/8 data bits and optional parity.
  Assumes serial_rx is synchronous to mclk and tick20 marks 20 MHz.
*/
`timescale 1ns/1ps
module uge_uart import uge_pkg::*; #(
  parameter logic [7:0] DIVISOR = BAUD_DIV
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic serial_rx,
  uge_uart_if.core  u
);
  logic [7:0]  baud_cnt;
  logic [3:0]  rx_cnt;
  logic [3:0]  rx_bitn;
  logic [8:0]  rx_shift;
  logic        rx_busy;
  logic [3:0]  tx_cnt;
  logic [3:0]  tx_left;
  logic [10:0] tx_shift;

  wire        baud_wrap = baud_cnt == DIVISOR; // R1
  wire        tick16    = ce && u.tick20 && baud_wrap;
  wire [3:0]  n_data    = u.char8 ? BITS_8 : BITS_7; // R3
  wire [3:0]  n_bits    = n_data + {3'h0, u.par_en}; // R4
  wire        rx_mid    = rx_cnt == MID_SAMPLE;
  wire        rx_stop   = rx_bitn == n_bits + 4'h1;
  wire [8:0]  rx_al     = rx_shift >> (SHIFT_W - n_bits);
  wire [7:0]  rx_word   = u.char8 ? rx_al[7:0] : {1'b0, rx_al[6:0]};
  wire        rx_pbit   = rx_al[n_data];
  wire        rx_perr   = u.par_en && ((^rx_word ^ rx_pbit) != u.par_odd); // R5
  wire [7:0]  tx_d      = u.char8 ? u.tx_data : {1'b0, u.tx_data[6:0]};
  wire        tx_p      = u.par_en ? (^tx_d ^ u.par_odd) : 1'b1; // R4 R5
  wire [10:0] tx_frame  = u.char8 ? {1'b1, tx_p, tx_d, 1'b0}
                                  : {2'b11, tx_p, tx_d[6:0], 1'b0};

  // Baud divisor on the 20 MHz enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      baud_cnt <= 8'h00;
    end else if (ce && u.tick20) begin
      baud_cnt <= baud_wrap ? 8'h00 : baud_cnt + 8'h01; // R1 R2
    end
  end

  // Receiver
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_busy    <= 1'b0;
      rx_cnt     <= 4'h0;
      rx_bitn    <= 4'h0;
      rx_shift   <= 9'h000;
      u.rx_valid <= 1'b0;
      u.rx_err   <= 1'b0;
      u.rx_data  <= 8'h00;
    end else if (ce) begin
      u.rx_valid <= 1'b0;
      if (tick16 && !rx_busy) begin
        rx_busy <= !serial_rx;
        rx_cnt  <= 4'h0;
        rx_bitn <= 4'h0;
      end else if (tick16) begin
        rx_cnt <= rx_cnt + 4'h1;
        if (rx_mid) begin
          rx_bitn <= rx_bitn + 4'h1;
          if (rx_bitn == 4'h0) begin
            rx_busy <= !serial_rx;
          end else if (rx_stop) begin
            rx_busy    <= 1'b0;
            u.rx_valid <= 1'b1;
            u.rx_data  <= rx_word;
            u.rx_err   <= rx_perr || !serial_rx;
          end else begin
            rx_shift <= {serial_rx, rx_shift[8:1]};
          end
        end
      end
    end
  end

  // Transmitter
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_shift  <= 11'h7ff;
      tx_left   <= 4'h0;
      tx_cnt    <= 4'h0;
      u.tx_busy <= 1'b0;
      u.tx_line <= 1'b1;
    end else if (ce) begin
      u.tx_line <= u.tx_busy ? tx_shift[0] : 1'b1;
      if (!u.tx_busy && u.tx_start) begin
        tx_shift  <= tx_frame;
        tx_left   <= n_bits + FRAME_EXTRA;
        tx_cnt    <= 4'h0;
        u.tx_busy <= 1'b1;
      end else if (u.tx_busy && tick16) begin
        tx_cnt <= tx_cnt + 4'h1;
        if (tx_cnt == LAST_SAMPLE) begin
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_left  <= tx_left - 4'h1;
          u.tx_busy <= tx_left != 4'h1;
        end
      end
    end
  end

  baud_range_a: assert property (@(posedge mclk) disable iff (rst)
    baud_cnt <= DIVISOR) else $error("baud counter past divisor"); // R1
  rx_width_a: assert property (@(posedge mclk) disable iff (rst)
    u.rx_valid && !u.char8 |-> !u.rx_data[7]) else $error("7-bit byte has bit 7"); // R3
  tx_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !u.tx_busy && !$past(u.tx_busy) |-> u.tx_line) else $error("line low while idle"); // R4
endmodule

// ===== src/uge_top.sv
/*
  Serial-command GPIO expander: four 8-bit ports behind a UART.
  Assumes port inputs and serial_rx are synchronous to mclk; the
  pad logic combines port_out and port_oe into the pins.
*/
// Summary of operation
// R1 - Baud is clock over sixteen times divisor+1
// R2 - 20 MHz UART clock, divisor gives 9600
// R3 - Width select: 8 bits if 1, else 7
// R4 - Parity enable covers receive and transmit
// R5 - Parity sense picks odd or even
// R6 - Top three bits address the port
// R7 - Low four bits are port directions
// R8 - Host addresses port as output before write
// R9 - Host addresses port as input before read
// R10 - After address, one byte written or read
// R11 - Write loads only addressed port register
// R12 - Port register holds until rewritten
// R13 - Read sends addressed port input value
// R14 - Four 8-bit ports, serial in and out
// R15 - 20 MHz UART timing from input clock
// R16 - State machine sequences UART and ports
// R17 - First byte address, then data or reply
// R18 - Output ports drive, input ports release
// R19 - Codes four to seven: no update, zero
// R20 - Reset clears data, directions input, idle
`timescale 1ns/1ps
module uge_top import uge_pkg::*; #(
  parameter logic [7:0] DIVISOR = BAUD_DIV // R1 R2
) (
  input  wire logic                              mclk,
  input  wire logic                              rst,
  input  wire logic                              ce,
  input  wire logic                              serial_rx,
  input  wire logic                              character_width_select,
  input  wire logic                              parity_enable,
  input  wire logic                              parity_odd,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] port_in,
  output logic                                   serial_tx,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0] port_out,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0] port_oe,
  output logic                                   rx_error
);
  uge_state_t state;
  uge_state_t next_state;
  logic [7:0] port_select_and_direction;
  logic [7:0] acc;
  logic       tick20;

  uge_uart_if u ();

  uge_uart #(.DIVISOR(DIVISOR)) core (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .serial_rx (serial_rx),
    .u         (u.core)
  );

  // 20 MHz enable from the system clock
  wire [8:0] acc_sum  = {1'b0, acc} + ACC_STEP;
  wire       acc_wrap = acc_sum >= ACC_WRAP;
  wire [8:0] acc_less = acc_sum - ACC_WRAP;
  wire [7:0] next_acc = acc_wrap ? acc_less[7:0] : acc_sum[7:0];

  // Static UART settings
  assign u.tick20  = tick20;
  assign u.char8   = character_width_select; // R3
  assign u.par_en  = parity_enable; // R4
  assign u.par_odd = parity_odd; // R5

  // Current selection
  wire [2:0] sel       = port_select_and_direction[ADDR_MSB:ADDR_LSB]; // R6
  wire       sel_ok    = sel <= LAST_PORT; // R19
  wire [1:0] sel_idx   = sel[1:0];
  wire [3:0] dir_bits  = port_select_and_direction[DIR_MSB:0]; // R7

  // Incoming byte decode
  wire       byte_ok   = u.rx_valid && !u.rx_err;
  wire [1:0] new_idx   = u.rx_data[ADDR_IDX:ADDR_LSB];
  wire       new_out   = u.rx_data[new_idx];
  wire       in_addr   = state == ST_WAIT_ADDR;
  wire       in_data   = state == ST_WAIT_DATA;
  wire       in_send   = state == ST_SEND_READ;
  wire       in_wait   = state == ST_WAIT_TX;
  wire       addr_take = in_addr && byte_ok; // R17
  wire       data_take = in_data && byte_ok;
  wire       wr_load   = data_take && sel_ok; // R11 R19

  // Read path
  wire [7:0] rd_port   = port_in[sel_idx];
  wire [7:0] rd_word   = sel_ok ? rd_port : READ_NONE; // R13 R19

  assign u.tx_data  = rd_word; // R13
  assign u.tx_start = in_send; // R16

  // Command sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_WAIT_ADDR: begin
        if (byte_ok) begin
          next_state = new_out ? ST_WAIT_DATA : ST_SEND_READ; // R10 R17
        end
      end
      ST_WAIT_DATA: begin
        if (byte_ok) begin
          next_state = ST_WAIT_ADDR; // R17
        end
      end
      ST_SEND_READ: begin
        if (!u.tx_busy) begin
          next_state = ST_WAIT_TX; // R16
        end
      end
      ST_WAIT_TX: begin
        if (!u.tx_busy) begin
          next_state = ST_WAIT_ADDR; // R17
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_WAIT_ADDR; // R20
    end else if (ce) begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      port_select_and_direction <= DIR_RESET; // R20
    end else if (ce && addr_take) begin
      port_select_and_direction <= u.rx_data; // R6 R7
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc    <= 8'h00;
      tick20 <= 1'b0;
    end else if (ce) begin
      acc    <= next_acc; // R15
      tick20 <= acc_wrap; // R15
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_tx <= 1'b1;
      rx_error  <= 1'b0;
    end else if (ce) begin
      serial_tx <= u.tx_line; // R14
      rx_error  <= u.rx_valid && u.rx_err;
    end
  end

  // Per-port data and drive enables
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    wire hit = wr_load && (sel_idx == 2'(i));
    always_ff @(posedge mclk) begin
      if (rst) begin
        port_out[i] <= DATA_RESET; // R20
        port_oe[i]  <= {PORT_W{1'b0}}; // R20
      end else if (ce) begin
        if (hit) begin
          port_out[i] <= u.rx_data; // R11 R12
        end
        if (addr_take) begin
          port_oe[i] <= {PORT_W{u.rx_data[i]}}; // R18
        end
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  reset_clear_a: assert property (
    $fell(rst) |-> port_out == '0 && port_oe == '0 && in_addr
  ) else $error("reset left state behind"); // R20

  addr_latch_a: assert property (
    ce && addr_take |=> port_select_and_direction == $past(u.rx_data)
  ) else $error("address byte not stored"); // R6

  oe_dir_a: assert property (
    port_oe == {{PORT_W{dir_bits[3]}}, {PORT_W{dir_bits[2]}},
                {PORT_W{dir_bits[1]}}, {PORT_W{dir_bits[0]}}}
  ) else $error("drive enable differs from direction"); // R18

  write_load_a: assert property (
    ce && wr_load |=> port_out[$past(sel_idx)] == $past(u.rx_data)
  ) else $error("write data not loaded"); // R11

  port_hold_a: assert property (
    !(ce && wr_load) |=> $stable(port_out)
  ) else $error("port data changed without write"); // R12

  read_sel_a: assert property (
    in_send && sel_ok |-> u.tx_data == port_in[sel_idx]
  ) else $error("wrong port sent"); // R13

  unused_addr_a: assert property (
    in_send && !sel_ok |-> u.tx_data == READ_NONE
  ) else $error("unused address not zero"); // R19

  unused_write_a: assert property (
    ce && data_take && !sel_ok |=> $stable(port_out)
  ) else $error("unused address updated port"); // R19

  data_done_a: assert property (
    ce && data_take |=> in_addr
  ) else $error("write did not return to idle"); // R17

  read_path_a: assert property (
    ce && addr_take && !new_out |=> in_send ##1 (in_send || in_wait)
  ) else $error("read not started"); // R10

  tick_rate_a: assert property (
    ce && tick20 |=> !tick20
  ) else $error("20 MHz enable too fast"); // R15

  tick_gap_a: assert property (
    ce && tick20 |=> !tick20 [*8]
  ) else $error("20 MHz enable spacing short"); // R15

  // Sequencer steps
  write_path_a: assert property (
    ce && addr_take && new_out |=> in_data
  ) else $error("write not started"); // R10

  addr_wait_a: assert property (
    ce && in_addr && !byte_ok |=> in_addr
  ) else $error("left idle without byte"); // R17

  data_wait_a: assert property (
    ce && in_data && !byte_ok |=> in_data
  ) else $error("left data wait without byte"); // R17

  read_hold_a: assert property (
    ce && in_send && u.tx_busy |=> in_send
  ) else $error("reply started while busy"); // R16

  tx_start_a: assert property (
    ce && in_send && !u.tx_busy |=> u.tx_busy && in_wait
  ) else $error("reply not launched"); // R16

  wait_hold_a: assert property (
    ce && in_wait && u.tx_busy |=> in_wait
  ) else $error("left reply early"); // R16

  wait_done_a: assert property (
    ce && in_wait && !u.tx_busy |=> in_addr
  ) else $error("no return after reply"); // R17

  // Register and port holds, and direction load
  select_hold_a: assert property (
    !(ce && addr_take) |=> $stable(port_select_and_direction)
  ) else $error("select register changed without byte"); // R6

  oe_hold_a: assert property (
    !(ce && addr_take) |=> $stable(port_oe)
  ) else $error("drive enable changed without byte"); // R18

  new_dir_a: assert property (
    ce && addr_take |=> port_oe[$past(new_idx)] == {PORT_W{$past(new_out)}}
  ) else $error("addressed port direction wrong"); // R18

  freeze_hold_a: assert property (
    !ce |=> $stable(state) && $stable(port_out) && $stable(port_oe)
  ) else $error("state moved while disabled"); // R12

  // Link checks
  bad_byte_a: assert property (
    ce && u.rx_valid && u.rx_err |=> $stable(port_select_and_direction) && $stable(port_out)
  ) else $error("errored byte was used"); // R4

  err_pulse_a: assert property (
    ce && u.rx_valid && u.rx_err |=> rx_error
  ) else $error("error pulse missing"); // R4

  err_quiet_a: assert property (
    ce && !u.rx_valid |=> !rx_error
  ) else $error("error pulse without byte"); // R4

  tx_copy_a: assert property (
    ce |=> serial_tx == $past(u.tx_line)
  ) else $error("serial output not from core line"); // R14

  write_cov: cover property (ce && wr_load);
  read_cov: cover property (in_send && sel_ok ##1 in_wait);
  unused_cov: cover property (in_send && !sel_ok);
  rx_err_cov: cover property (u.rx_valid && u.rx_err);
  dir_cov: cover property (ce && addr_take && new_out);
endmodule

// ===== verification/uge_host_model.sv
/*
  Host end of the serial link: sends command and data frames and
  receives reply frames. Assumes it shares mclk with the expander.
*/
`timescale 1ns/1ps
module uge_host_model import uge_pkg::*; #(
  parameter logic [7:0] DIVISOR = BAUD_DIV
) (
  input  wire logic mclk,
  input  wire logic serial_tx,
  output logic      serial_rx
);
  // Bit time from the 16x divisor at the UART rate
  localparam int BIT_CYC = OVERSAMPLE * (int'(DIVISOR) + 1) * MCLK_MHZ / UART_CLK_MHZ;

  initial serial_rx = 1'b1;

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Start, 8 or 7 data bits LSB first, optional parity, stop
  task automatic send_byte(input logic [7:0] d, input logic w8, input logic pe,
                           input logic po, input logic bad);
    logic [10:0] f;
    logic [7:0]  dd;
    logic        pb;
    int          i;
    dd = w8 ? d : {1'b0, d[6:0]};
    pb = pe ? ((po ? ~^dd : ^dd) ^ bad) : 1'b1;
    f  = w8 ? {1'b1, pb, dd, 1'b0} : {2'b11, pb, dd[6:0], 1'b0};
    wait_cyc(1);
    for (i = 0; i < (w8 ? 10 : 9) + (pe ? 1 : 0); i++) begin
      serial_rx = f[i];
      wait_cyc(BIT_CYC);
    end
  endtask

  task automatic recv_byte(input logic pe, output logic [7:0] d, output logic p,
                           output logic stop, output logic seen);
    int i;
    seen = 1'b0;
    for (i = 0; i < 12 * BIT_CYC && !seen; i++) begin
      wait_cyc(1);
      seen = (serial_tx === 1'b0);
    end
    wait_cyc(BIT_CYC / 2);
    for (i = 0; i < 8; i++) begin
      wait_cyc(BIT_CYC);
      d[i] = serial_tx;
    end
    p = 1'b0;
    if (pe) begin
      wait_cyc(BIT_CYC);
      p = serial_tx;
    end
    wait_cyc(BIT_CYC);
    stop = serial_tx;
    // Idle until the reply frame has ended
    wait_cyc(BIT_CYC);
  endtask
endmodule

// ===== verification/tb.sv
/*
  Self-checking bench of the serial GPIO expander.
  Assumes the host model drives serial_rx and watches serial_tx.
*/
`timescale 1ns/1ps
module tb import uge_pkg::*; ;
  logic                             mclk, rst, ce, character_width_select;
  logic                             parity_enable, parity_odd, serial_rx, serial_tx;
  logic                             rx_error, err_seen;
  logic [NUM_PORTS-1:0][PORT_W-1:0] port_in, port_out, port_oe;
  int                               fail_count, tests_run;

  // Short bit time keeps the run brief
  localparam logic [7:0] TB_DIV = 8'h01;

  uge_top #(.DIVISOR(TB_DIV)) dut (
    .mclk(mclk), .rst(rst), .ce(ce), .serial_rx(serial_rx),
    .character_width_select(character_width_select),
    .parity_enable(parity_enable), .parity_odd(parity_odd),
    .port_in(port_in), .serial_tx(serial_tx), .port_out(port_out),
    .port_oe(port_oe), .rx_error(rx_error)
  );

  uge_host_model #(.DIVISOR(TB_DIV)) host (
    .mclk(mclk), .serial_tx(serial_tx), .serial_rx(serial_rx)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (rst) err_seen <= 1'b0;
    else if (rx_error === 1'b1) err_seen <= 1'b1;
  end

  task automatic complete_run;
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
    check_word({24'h0, got}, {24'h0, exp}, what);
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_word({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic read_port(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] d;
    logic       p, stop, seen;
    fork
      host.send_byte(cmd, character_width_select, parity_enable, parity_odd, 1'b0);
      host.recv_byte(parity_enable, d, p, stop, seen);
    join
    check_bit(seen, 1'b1, "reply start");
    check_byte(d, exp, "reply data");
    if (parity_enable) check_bit(p, parity_odd ? ~^exp : ^exp, "parity");
    check_bit(stop, 1'b1, "reply stop");
  endtask

  initial begin
    ce = 1'b1;
    character_width_select = 1'b1;
    parity_enable = 1'b0;
    parity_odd = 1'b0;
    port_in = {8'h3c, 8'h96, 8'h5a, 8'hc3};
    rst = 1'b1;
    fail_count = 0;
    tests_run = 0;
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    @(posedge mclk);
    #1;
    check_word(port_out, 32'h0, "reset out");
    check_word(port_oe, 32'h0, "reset oe");
    check_bit(serial_tx, 1'b1, "tx idle");
    host.send_byte(8'h44, 1'b1, 1'b0, 1'b0, 1'b0);
    check_word(port_oe, 32'h00ff0000, "oe port c");
    ce = 1'b0;
    repeat (20) @(posedge mclk);
    #1 ce = 1'b1;
    host.send_byte(8'ha5, 1'b1, 1'b0, 1'b0, 1'b0);
    check_word(port_out, 32'h00a50000, "write c");
    parity_enable = 1'b1;
    read_port(8'h20, 8'h5a);
    check_word(port_oe, 32'h0, "oe released");
    check_word(port_out, 32'h00a50000, "hold c");
    check_bit(err_seen, 1'b0, "no error");
    parity_enable = 1'b0;
    read_port(8'h80, 8'h00);
    parity_enable = 1'b1;
    parity_odd = 1'b1;
    host.send_byte(8'h44, 1'b1, 1'b1, 1'b1, 1'b1);
    check_bit(err_seen, 1'b1, "parity error");
    check_word(port_oe, 32'h0, "bad byte");
    read_port(8'h60, 8'h3c);
    character_width_select = 1'b0;
    host.send_byte(8'h44, 1'b0, 1'b1, 1'b1, 1'b0);
    check_word(port_oe, 32'h00ff0000, "oe 7 bit");
    host.send_byte(8'ha5, 1'b0, 1'b1, 1'b1, 1'b0);
    check_word(port_out, 32'h00250000, "write 7 bit");
    complete_run;
  end

  initial begin
    repeat (80000) @(posedge mclk);
    fail_count++;
    complete_run;
  end
endmodule
